// File: shared/uie_pkg.sv
// Summary of operation
// - Writing one to set register enables event
// - Writing one to clear register disables event
// - Set register reads back shared enable state
// - Clear register reads back same enable state
// - Eleven events, each enable bit independent
// - Clear register decoded at its own offset
// - Combined enable word shares one state
package uie_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_EV = 11;
    localparam int STRB_W = DATA_W / 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_WORD = 12'h300;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_SET = 12'h304;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
    localparam logic [ADDR_W-1:0] OFS_EVENT_PENDING = 12'h30c;

    // Bit positions of the event fields
    localparam int BIT_CLEAR_TO_SEND_ASSERTED_EVENT = 0;
    localparam int BIT_CLEAR_TO_SEND_RELEASED_EVENT = 1;
    localparam int BIT_RECEIVE_BYTE_READY_EVENT = 2;
    localparam int BIT_RECEIVE_BUFFER_END_EVENT = 3;
    localparam int BIT_TRANSMIT_BYTE_READY_EVENT = 4;
    localparam int BIT_TRANSMIT_BUFFER_END_EVENT = 5;
    localparam int BIT_LINE_ERROR_EVENT = 6;
    localparam int BIT_RECEIVE_TIMEOUT_EVENT = 7;
    localparam int BIT_RECEIVE_BEGUN_EVENT = 8;
    localparam int BIT_TRANSMIT_BEGUN_EVENT = 9;
    localparam int BIT_TRANSMIT_HALTED_EVENT = 10;

    localparam logic [NUM_EV-1:0] IRQ_ENABLE_RST = 11'h000;
    localparam logic [NUM_EV-1:0] EVENT_PENDING_RST = 11'h000;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    typedef logic [NUM_EV-1:0] uie_ev_t;

    typedef enum {
        SEL_NONE,
        SEL_WORD,
        SEL_SET,
        SEL_CLEAR,
        SEL_PENDING
    } uie_sel_t;

    // Register update request handed to the enable bank
    typedef struct packed {
        logic word_we;
        uie_ev_t word_val;
        uie_ev_t word_mask;
        uie_ev_t set_mask;
        uie_ev_t clr_mask;
        uie_ev_t pend_clr;
    } uie_cmd_t;

    typedef struct packed {
        uie_ev_t enable;
        uie_ev_t pending;
        logic irq;
    } uie_bank_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic slverr;
    } uie_slv_state_t;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } uie_rst_state_t;

endpackage

// File: hdl/uie_rst_sync.sv
`timescale 1ns/1ps
module uie_rst_sync
    import uie_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    output logic rst_n_o
);

    uie_rst_state_t s_q;
    uie_rst_state_t s_d;

    // First stage feeds only the second stage
    always_comb
    begin
        s_d.stage1 = 1'b1;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rst_n_o = s_q.stage2;

endmodule

// File: hdl/uie_enable_bank.sv
`timescale 1ns/1ps
module uie_enable_bank
    import uie_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire uie_cmd_t cmd_i,
    input wire uie_ev_t event_i,
    output uie_ev_t enable_o,
    output uie_ev_t pending_o,
    output logic irq_o
);

    uie_bank_state_t s_q;
    uie_bank_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (cmd_i.word_we)
        begin
            s_d.enable = (s_q.enable & ~cmd_i.word_mask)
                | (cmd_i.word_val & cmd_i.word_mask);
        end
        s_d.enable = s_d.enable | cmd_i.set_mask;
        s_d.enable = s_d.enable & ~cmd_i.clr_mask;
        // A new event beats a clear in the same cycle
        s_d.pending = (s_q.pending & ~cmd_i.pend_clr) | event_i;
        s_d.irq = |(s_q.pending & s_q.enable);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q.enable <= IRQ_ENABLE_RST;
            s_q.pending <= EVENT_PENDING_RST;
            s_q.irq <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign enable_o = s_q.enable;
    assign pending_o = s_q.pending;
    assign irq_o = s_q.irq;

endmodule

// File: hdl/uie_irq_enable_top.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module uie_irq_enable_top
    import uie_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [DATA_W-1:0] PWDATA_I,
    input wire logic [STRB_W-1:0] PSTRB_I,
    output logic PREADY_O,
    output logic [DATA_W-1:0] PRDATA_O,
    output logic PSLVERR_O,
    input wire logic [NUM_EV-1:0] EVENT_I,
    output logic [NUM_EV-1:0] IRQ_ENABLE_O,
    output logic IRQ_O
);

    function automatic uie_sel_t decode(input logic [ADDR_W-1:0] addr);
        uie_sel_t sel;
        case (addr)
            OFS_IRQ_ENABLE_WORD: sel = SEL_WORD;
            OFS_IRQ_ENABLE_SET: sel = SEL_SET;
            OFS_IRQ_ENABLE_CLEAR: sel = SEL_CLEAR;
            OFS_EVENT_PENDING: sel = SEL_PENDING;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    function automatic uie_ev_t lane_mask(input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < STRB_W; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m[NUM_EV-1:0];
    endfunction

    logic rst_n;
    uie_sel_t sel;
    logic setup_ph;
    logic access_wr;
    uie_ev_t wmask;
    uie_ev_t enable;
    uie_ev_t pending;
    uie_cmd_t cmd;
    uie_slv_state_t s_q;
    uie_slv_state_t s_d;

    uie_rst_sync u_rst_sync (
        .clk_i(CLK_SYS_I),
        .rst_b_i(RST_B_I),
        .rst_n_o(rst_n)
    );

    assign sel = decode(PADDR_I);
    assign setup_ph = PSEL_I & ~PENABLE_I;
    assign access_wr = PSEL_I & PENABLE_I & PWRITE_I;
    // Only strobed lanes carry write data
    assign wmask = PWDATA_I[NUM_EV-1:0] & lane_mask(PSTRB_I);

    always_comb
    begin
        cmd = '0;
        if (access_wr)
        begin
            case (sel)
                SEL_WORD:
                begin
                    cmd.word_we = 1'b1;
                    cmd.word_val = PWDATA_I[NUM_EV-1:0];
                    cmd.word_mask = lane_mask(PSTRB_I);
                end
                SEL_SET: cmd.set_mask = wmask;
                SEL_CLEAR: cmd.clr_mask = wmask;
                SEL_PENDING: cmd.pend_clr = wmask;
                default: cmd = '0;
            endcase
        end
    end

    uie_enable_bank u_bank (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .cmd_i(cmd),
        .event_i(EVENT_I),
        .enable_o(enable),
        .pending_o(pending),
        .irq_o(IRQ_O)
    );

    // Read data and error are captured in the setup cycle
    always_comb
    begin
        s_d = s_q;
        if (setup_ph)
        begin
            s_d.slverr = (sel == SEL_NONE);
            case (sel)
                SEL_WORD: s_d.prdata = DATA_W'(enable);
                SEL_SET: s_d.prdata = DATA_W'(enable);
                SEL_CLEAR: s_d.prdata = DATA_W'(enable);
                SEL_PENDING: s_d.prdata = DATA_W'(pending);
                default: s_d.prdata = RDATA_RST;
            endcase
            if (PWRITE_I)
            begin
                s_d.prdata = RDATA_RST;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.prdata <= RDATA_RST;
            s_q.slverr <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign PREADY_O = 1'b1;
    assign PRDATA_O = s_q.prdata;
    assign PSLVERR_O = s_q.slverr;
    assign IRQ_ENABLE_O = enable;

    logic wr_set;
    logic wr_clr;
    logic wr_word;
    logic rd_set;
    logic rd_clr;
    uie_ev_t word_bm;

    assign wr_set = access_wr && sel == SEL_SET;
    assign wr_clr = access_wr && sel == SEL_CLEAR;
    assign wr_word = access_wr && sel == SEL_WORD;
    assign rd_set = PSEL_I && PENABLE_I && !PWRITE_I && sel == SEL_SET;
    assign rd_clr = PSEL_I && PENABLE_I && !PWRITE_I && sel == SEL_CLEAR;
    assign word_bm = lane_mask(PSTRB_I);

    chk_set_applies: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_set |=> (enable & $past(wmask)) == $past(wmask))
    else $error("set write did not enable bits");

    chk_set_keeps: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_set |=> (enable & ~$past(wmask))
            == ($past(enable) & ~$past(wmask)))
    else $error("set write changed unwritten bits");

    chk_clr_applies: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_clr |=> (enable & $past(wmask)) == '0)
    else $error("clear write did not disable bits");

    chk_clr_keeps: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_clr |=> (enable | $past(wmask))
            == ($past(enable) | $past(wmask)))
    else $error("clear write changed unwritten bits");

    chk_clr_decode: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_clr |=> (enable & ~$past(enable)) == '0)
    else $error("clear offset enabled a bit");

    chk_set_readback: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        rd_set |-> PRDATA_O == DATA_W'(enable) && !PSLVERR_O)
    else $error("set register read mismatch");

    chk_clr_readback: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        rd_clr |-> PRDATA_O == DATA_W'(enable) && !PSLVERR_O)
    else $error("clear register read mismatch");

    chk_word_shared: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_word |=> enable == (($past(enable) & ~$past(word_bm))
            | ($past(PWDATA_I[NUM_EV-1:0]) & $past(word_bm))))
    else $error("enable word write mismatch");

    chk_reset_zero: assert property (
        @(posedge CLK_SYS_I) $rose(rst_n) |-> enable == IRQ_ENABLE_RST)
    else $error("enables not zero after reset");

    chk_irq_gated: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        ##1 IRQ_O == $past(|(pending & enable)))
    else $error("interrupt not gated by enables");

    chk_pend_sticky: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        |EVENT_I |=> (pending & $past(EVENT_I)) == $past(EVENT_I))
    else $error("event lost from pending");

    chk_ready_high: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        PREADY_O == 1'b1)
    else $error("ready not high");

    chk_unmapped_err: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        PSEL_I && PENABLE_I && sel == SEL_NONE |-> PSLVERR_O)
    else $error("unmapped access without error");

    chk_mapped_ok: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        PSEL_I && PENABLE_I && sel != SEL_NONE |-> !PSLVERR_O)
    else $error("mapped access flagged as error");

    chk_unmapped_ignored: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        access_wr && sel == SEL_NONE |=> enable == $past(enable))
    else $error("unmapped write changed enables");

    chk_rdata_upper: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        PRDATA_O[DATA_W-1:NUM_EV] == '0)
    else $error("unused read bits not zero");

    chk_idle_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        !access_wr |=> enable == $past(enable))
    else $error("enables changed without a write");

    chk_set_no_clear: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_set |=> ($past(enable) & ~enable) == '0)
    else $error("set write cleared a bit");

    chk_irq_none: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        !(|(pending & enable)) |=> !IRQ_O)
    else $error("interrupt without enabled event");

    chk_write_rdata: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        access_wr |-> PRDATA_O == RDATA_RST)
    else $error("read data not zero during write");

    chk_word_readback: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        PSEL_I && PENABLE_I && !PWRITE_I && sel == SEL_WORD
            |-> PRDATA_O == DATA_W'(enable))
    else $error("enable word read mismatch");

    chk_pend_clear: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        access_wr && sel == SEL_PENDING
            |=> (pending & $past(wmask) & ~$past(EVENT_I)) == '0)
    else $error("pending clear not applied");

    chk_pend_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        !(access_wr && sel == SEL_PENDING)
            |=> (pending & $past(pending)) == $past(pending))
    else $error("pending bit lost without clear");

    chk_clr_no_set: assert property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        wr_clr |=> (enable & ~$past(enable)) == '0)
    else $error("clear write set a bit");

    chk_rst_outputs: assert property (
        @(posedge CLK_SYS_I) !rst_n |-> !IRQ_O && PRDATA_O == RDATA_RST)
    else $error("outputs not idle in reset");

    cov_word_write: cover property (
        @(posedge CLK_SYS_I) disable iff (!rst_n) wr_word);

    cov_set_write: cover property (
        @(posedge CLK_SYS_I) disable iff (!rst_n) wr_set && |wmask);

    cov_clr_write: cover property (
        @(posedge CLK_SYS_I) disable iff (!rst_n) wr_clr && |wmask);

    cov_irq_rise: cover property (
        @(posedge CLK_SYS_I) disable iff (!rst_n) $rose(IRQ_O));

    cov_unmapped: cover property (
        @(posedge CLK_SYS_I) disable iff (!rst_n)
        PSEL_I && PENABLE_I && PSLVERR_O);

endmodule

// File: test/uie_irq_enable_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end

module uie_irq_enable_top_tb
    import uie_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [STRB_W-1:0] pstrb = '1;
    logic [NUM_EV-1:0] ev = '0;
    logic pready;
    logic [DATA_W-1:0] prdata;
    logic pslverr;
    logic [NUM_EV-1:0] irq_en;
    logic irq;
    int n_errors = 0;
    int n_tests = 0;

    uie_irq_enable_top dut (
        .CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .EVENT_I(ev),
        .IRQ_ENABLE_O(irq_en), .IRQ_O(irq)
    );

    always #25 clk = ~clk;

    task end_of_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Setup, then access held until pready is seen high at an edge
    task apb(input logic w, input logic [ADDR_W-1:0] a,
             input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
             output logic err);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] v;
        logic e;
        apb(1'b1, a, d, v, e);
    endtask

    task pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
    endtask

    task wait_irq(input logic ex);
        int k;
        for (k = 0; k < 10; k++)
        begin
            @(posedge clk);
            if (irq === ex)
                break;
        end
        `CHK("irq", ex, irq)
    endtask

    task t_reset;
        logic [DATA_W-1:0] v;
        logic e;
        `CHK("enable pins", 11'h000, irq_en)
        `CHK("irq", 1'b0, irq)
        apb(1'b0, OFS_IRQ_ENABLE_SET, '0, v, e);
        `CHK("set reg", 32'h0000_0000, v)
        apb(1'b0, OFS_IRQ_ENABLE_CLEAR, '0, v, e);
        `CHK("clear reg", 32'h0000_0000, v)
    endtask

    task t_set;
        logic [DATA_W-1:0] v, ex;
        logic e;
        ex = '0;
        for (int i = 0; i < NUM_EV; i++)
        begin
            wr(OFS_IRQ_ENABLE_SET, 32'h0000_0001 << i);
            ex[i] = 1'b1;
            apb(1'b0, OFS_IRQ_ENABLE_SET, '0, v, e);
            `CHK("set reg", ex, v)
            apb(1'b0, OFS_IRQ_ENABLE_CLEAR, '0, v, e);
            `CHK("clear reg", ex, v)
            `CHK("enable pins", ex[NUM_EV-1:0], irq_en)
        end
    endtask

    task t_clear;
        logic [DATA_W-1:0] v, ex;
        logic e;
        ex = 32'h0000_07ff;
        for (int i = 0; i < NUM_EV; i++)
        begin
            wr(OFS_IRQ_ENABLE_CLEAR, 32'h0000_0001 << i);
            ex[i] = 1'b0;
            apb(1'b0, OFS_IRQ_ENABLE_CLEAR, '0, v, e);
            `CHK("clear reg", ex, v)
            apb(1'b0, OFS_IRQ_ENABLE_SET, '0, v, e);
            `CHK("set reg", ex, v)
        end
    endtask

    task t_word;
        logic [DATA_W-1:0] v;
        logic e;
        wr(OFS_IRQ_ENABLE_WORD, 32'hffff_ffff);
        apb(1'b0, OFS_IRQ_ENABLE_SET, '0, v, e);
        `CHK("set reg", 32'h0000_07ff, v)
        wr(OFS_IRQ_ENABLE_WORD, 32'h0000_0155);
        wr(OFS_IRQ_ENABLE_SET, 32'h0000_0002);
        apb(1'b0, OFS_IRQ_ENABLE_WORD, '0, v, e);
        `CHK("word reg", 32'h0000_0157, v)
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h0000_0104);
        apb(1'b0, OFS_IRQ_ENABLE_WORD, '0, v, e);
        `CHK("word reg", 32'h0000_0053, v)
        wr(12'h310, 32'h0000_07ff);
        apb(1'b0, 12'h310, '0, v, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0000_0000, v)
        `CHK("enable pins", 11'h053, irq_en)
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h0000_07ff);
    endtask

    task t_irq;
        logic [DATA_W-1:0] v;
        logic e;
        wr(OFS_IRQ_ENABLE_SET, 32'h1 << BIT_RECEIVE_BYTE_READY_EVENT);
        pulse(BIT_TRANSMIT_HALTED_EVENT);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        wr(OFS_IRQ_ENABLE_SET, 32'h1 << BIT_TRANSMIT_HALTED_EVENT);
        wait_irq(1'b1);
        wr(OFS_IRQ_ENABLE_CLEAR, 32'h1 << BIT_TRANSMIT_HALTED_EVENT);
        wait_irq(1'b0);
        wr(OFS_EVENT_PENDING, 32'h0000_07ff);
        wr(OFS_IRQ_ENABLE_SET, 32'h1 << BIT_TRANSMIT_HALTED_EVENT);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        pulse(BIT_RECEIVE_BYTE_READY_EVENT);
        wait_irq(1'b1);
        apb(1'b0, OFS_IRQ_ENABLE_SET, '0, v, e);
        `CHK("set reg", 32'h0000_0404, v)
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_set();
        t_clear();
        t_word();
        t_irq();
        end_of_test();
    end
endmodule
